/* File: emb_ram_pkg.sv */
// shared constants, width modes and lane decode for the embedded ram block
// assumes one system clock; port clocks arrive as synchronous strobes
package emb_ram_pkg;

   // ==========================================================
   // geometry
   localparam int             DEPTH    = 128;
   localparam int             DATA_W   = 36;
   localparam int             ADDR_W   = 7;
   localparam int             LANES    = 4;
   localparam int             LANE_W   = 9;
   localparam int             HALF_W   = 6;    // address bits of one split half

   // ==========================================================
   // write port width modes
   localparam logic [2:0]     WM_X36   = 3'h0;
   localparam logic [2:0]     WM_X32   = 3'h1;
   localparam logic [2:0]     WM_X18   = 3'h2;
   localparam logic [2:0]     WM_X16   = 3'h3;
   localparam logic [2:0]     WM_NARROW = 3'h4; // any code from here up: no masking

   // ==========================================================
   // reset values
   localparam logic [DATA_W-1:0] Q_RESET    = 36'h0_0000_0000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
   localparam logic [LANES-1:0]  MASK_RESET = 4'h0;

   // ==========================================================
   // expand lane mask to per-bit write enables for a width mode
   function automatic logic [DATA_W-1:0] bit_enable(input logic [2:0]       mode,
                                                    input logic [LANES-1:0] lane);
      logic [DATA_W-1:0] be;
      logic              wide;
      logic              byte8;
      be    = '0;
      wide  = (mode == WM_X36) || (mode == WM_X32);
      byte8 = (mode == WM_X32) || (mode == WM_X16);
      if (mode >= WM_NARROW)
      begin
         be = '1;
      end
      else
      begin
         for (int l = 0; l < LANES; l++)
         begin
            for (int b = 0; b < LANE_W; b++)
            begin
               if (lane[l] && (wide || l < 2) && !(byte8 && b == LANE_W - 1))
               begin
                  be[l*LANE_W+b] = 1'b1;
               end
            end
         end
      end
      return be;
   endfunction

endpackage

/* File: emb_ram_core.sv */
// storage array with two bit-masked write ports and two read ports
// assumes callers present registered addresses; read data is combinational
`timescale 1ns/10ps
`default_nettype none

module emb_ram_core
   import emb_ram_pkg::*;
#(
   parameter int DEPTH_P = DEPTH,
   parameter int WIDTH_P = DATA_W
)
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // port a
   input  wire logic                 we_a,
   input  wire logic [ADDR_W-1:0]    addr_a,
   input  wire logic [WIDTH_P-1:0]   bit_en_a,
   input  wire logic [WIDTH_P-1:0]   wdata_a,
   output logic      [WIDTH_P-1:0]   rdata_a,
   // port b
   input  wire logic                 we_b,
   input  wire logic [ADDR_W-1:0]    addr_b,
   input  wire logic [WIDTH_P-1:0]   bit_en_b,
   input  wire logic [WIDTH_P-1:0]   wdata_b,
   output logic      [WIDTH_P-1:0]   rdata_b
);

   // ==========================================================
   // storage
   // full word array
   logic [WIDTH_P-1:0] mem [DEPTH_P];

   // masked writes, port b last so it wins a same-address clash
   // unmasked bits keep value
   always_ff @(posedge clk)
   begin
      if (we_a)
      begin
         mem[addr_a] <= (mem[addr_a] & ~bit_en_a) | (wdata_a & bit_en_a);
      end
      if (we_b)
      begin
         mem[addr_b] <= (mem[addr_b] & ~bit_en_b) | (wdata_b & bit_en_b);
      end
   end

   // read both ports
   assign rdata_a = mem[addr_a];
   assign rdata_b = mem[addr_b];

   // ==========================================================
   // checks
   logic [WIDTH_P-1:0] old_word;
   logic [WIDTH_P-1:0] old_keep;
   logic [ADDR_W-1:0]  old_addr;
   logic               old_we;

   // snapshot of the word before a port a write
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         old_word <= '0;
         old_keep <= '0;
         old_addr <= ADDR_RESET;
         old_we   <= 1'b0;
      end
      else
      begin
         old_word <= mem[addr_a];
         old_keep <= ~bit_en_a;
         old_addr <= addr_a;
         old_we   <= we_a && !(we_b && addr_b == addr_a);
      end
   end

   a_keep_lanes: assert property (@(posedge clk) disable iff (!rst_n)
      old_we |-> (mem[old_addr] & old_keep) == (old_word & old_keep))
      else $error("masked-off bits changed on write");

endmodule

`default_nettype wire

/* File: embedded_ram_block.sv */
// embedded ram block: 128 x 36 array with two ports, lane masked writes,
// selectable port clocks, bypassable output register, single-port and split modes
// assumes port clocks arrive as one-cycle strobes synchronous to clk
`timescale 1ns/10ps
`default_nettype none

module embedded_ram_block
   import emb_ram_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // configuration
   input  wire logic [2:0]           width_mode_a,
   input  wire logic [2:0]           width_mode_b,
   input  wire logic                 single_port,
   input  wire logic                 split_mode,
   input  wire logic                 bypass_a,
   input  wire logic                 bypass_b,
   input  wire logic                 in_clk_sel_a,
   input  wire logic                 in_clk_sel_b,
   input  wire logic                 out_clk_sel_a,
   input  wire logic                 out_clk_sel_b,
   // port a controls
   input  wire logic                 clock_a,
   input  wire logic                 clocken_a,
   input  wire logic                 renwe_a,
   input  wire logic                 clr_a,
   // port a data
   input  wire logic [ADDR_W-1:0]    addr_a,
   input  wire logic [LANES-1:0]     lane_mask_a,
   input  wire logic [DATA_W-1:0]    wdata_a,
   output logic      [DATA_W-1:0]    q_a,
   // port b controls
   input  wire logic                 clock_b,
   input  wire logic                 clocken_b,
   input  wire logic                 renwe_b,
   input  wire logic                 clr_b,
   // port b data
   input  wire logic [ADDR_W-1:0]    addr_b,
   input  wire logic [LANES-1:0]     lane_mask_b,
   input  wire logic [DATA_W-1:0]    wdata_b,
   output logic      [DATA_W-1:0]    q_b
);

   // ==========================================================
   // port vectors
   logic [1:0]              port_tick;
   logic [1:0]              in_tick;
   logic [1:0]              out_tick;
   logic [1:0]              active;
   logic [1:0]              renwe_in;
   logic [1:0]              clr_in;
   logic [1:0]              bypass_in;
   logic [2:0]              mode_in  [2];
   logic [ADDR_W-1:0]       addr_in  [2];
   logic [LANES-1:0]        mask_in  [2];
   logic [DATA_W-1:0]       data_in  [2];
   logic [ADDR_W-1:0]       addr_r   [2];
   logic [LANES-1:0]        mask_r   [2];
   logic [DATA_W-1:0]       data_r   [2];
   logic [1:0]              we_r;
   logic [1:0]              wpend;
   logic [1:0]              rpend;
   logic [ADDR_W-1:0]       ea       [2];
   logic [DATA_W-1:0]       be       [2];
   logic [DATA_W-1:0]       rd1      [2];
   logic [DATA_W-1:0]       q_r      [2];
   logic [DATA_W-1:0]       rd_a;
   logic [DATA_W-1:0]       rd_b;

   assign port_tick    = {clock_b & clocken_b, clock_a & clocken_a};
   // input and output sides pick their clock apart
   // each register group on either clock
   assign in_tick[0]   = port_tick[in_clk_sel_a];
   assign in_tick[1]   = port_tick[in_clk_sel_b];
   assign out_tick[0]  = port_tick[out_clk_sel_a];
   assign out_tick[1]  = port_tick[out_clk_sel_b];
   // single-port mode leaves port b idle
   assign active       = {~single_port, 1'b1};
   assign renwe_in     = {renwe_b, renwe_a};
   assign clr_in       = {clr_b, clr_a};
   assign bypass_in    = {bypass_b, bypass_a};
   assign mode_in[0]   = width_mode_a;
   assign mode_in[1]   = width_mode_b;
   assign addr_in[0]   = addr_a;
   assign addr_in[1]   = addr_b;
   assign mask_in[0]   = lane_mask_a;
   assign mask_in[1]   = lane_mask_b;
   assign data_in[0]   = wdata_a;
   assign data_in[1]   = wdata_b;

   // ==========================================================
   // input registers
   // select, address, mask and data always registered
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int p = 0; p < 2; p++)
         begin
            addr_r[p] <= ADDR_RESET;
            mask_r[p] <= MASK_RESET;
            data_r[p] <= Q_RESET;
         end
         we_r <= 2'h0;
      end
      else
      begin
         for (int p = 0; p < 2; p++)
         begin
            if (in_tick[p])
            begin
               we_r[p]   <= renwe_in[p];
               addr_r[p] <= addr_in[p];
               mask_r[p] <= mask_in[p];
               data_r[p] <= data_in[p];
            end
         end
      end
   end

   // one-cycle write and read requests from a captured access
   // select picks read or write, never both
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wpend <= 2'h0;
         rpend <= 2'h0;
      end
      else
      begin
         wpend <= in_tick & renwe_in & active;
         rpend <= in_tick & ~renwe_in & active;
      end
   end

   // ==========================================================
   // address mapping and lane decode
   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         ea[p] = addr_r[p];
         // split mode pins each port to its own 64 x 36 half
         if (split_mode)
         begin
            ea[p][ADDR_W-1] = 1'(p);
         end
         // lane n gates bits 9n+8 to 9n
         // any mask pattern decoded as given in x36/x32; x18/x16 drop lanes 2 and 3, narrow modes ignore it
         // 8-bit lanes skip the ninth bit
         be[p] = bit_enable(mode_in[p], mask_r[p]);
      end
   end

   // storage
   emb_ram_core #(
      .DEPTH_P  (DEPTH),
      .WIDTH_P  (DATA_W)
   ) u_core (
      .clk      (clk),
      .rst_n    (rst_n),
      .we_a     (wpend[0]),
      .addr_a   (ea[0]),
      .bit_en_a (be[0]),
      .wdata_a  (data_r[0]),
      .rdata_a  (rd_a),
      .we_b     (wpend[1]),
      .addr_b   (ea[1]),
      .bit_en_b (be[1]),
      .wdata_b  (data_r[1]),
      .rdata_b  (rd_b)
   );

   // ==========================================================
   // read path and output registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int p = 0; p < 2; p++)
         begin
            rd1[p] <= Q_RESET;
            q_r[p] <= Q_RESET;
         end
      end
      else
      begin
         for (int p = 0; p < 2; p++)
         begin
            if (rpend[p])
            begin
               rd1[p] <= (p == 0) ? rd_a : rd_b;
            end
            if (clr_in[p])
            begin
               q_r[p] <= Q_RESET;
            end
            // bypass skips only the output stage
            else if (bypass_in[p])
            begin
               if (rpend[p])
               begin
                  q_r[p] <= (p == 0) ? rd_a : rd_b;
               end
            end
            else if (out_tick[p])
            begin
               q_r[p] <= rd1[p];
            end
         end
      end
   end

   assign q_a = q_r[0];
   assign q_b = q_r[1];

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_read_cap_a;
      in_tick[0] && !renwe_a && !clr_a && bypass_a;
   endsequence

   sequence s_read_done_a;
      rpend[0] && !clr_a && bypass_a;
   endsequence

   a_bypass_path: assert property (
      s_read_cap_a ##1 s_read_done_a |=> q_r[0] == $past(rd_a))
      else $error("bypassed read data not presented");

   a_out_stage: assert property (
      !bypass_a && out_tick[0] && !clr_a |=> q_r[0] == $past(rd1[0]))
      else $error("output register missed its clock");

   a_clear_out: assert property (
      clr_a ##0 clr_b |=> q_a == Q_RESET && q_b == Q_RESET)
      else $error("clear did not zero output");

   a_gate_hold: assert property (
      !in_tick[1] |=> $stable(addr_r[1]) && $stable(data_r[1]) && $stable(mask_r[1]))
      else $error("gated port registers changed");

   a_write_cause: assert property (
      wpend[0] |-> $past(in_tick[0]) && $past(renwe_a))
      else $error("write without a port clock");

   a_sel_clock: assert property (
      !in_clk_sel_b && !clock_a && clock_b && clocken_b |=> !wpend[1] && !rpend[1])
      else $error("port b inputs took the wrong clock");

   a_sp_quiet_b: assert property (
      single_port |=> !wpend[1] && !rpend[1] && !(wpend[0] && rpend[0]))
      else $error("port b active in single-port mode");

   a_split_half: assert property (
      split_mode |-> ea[0][ADDR_W-1] == 1'b0 && ea[1][ADDR_W-1] == 1'b1)
      else $error("split port left its half");

   a_narrow_full: assert property (
      width_mode_a >= WM_NARROW |-> be[0] == '1)
      else $error("narrow width masked");

   a_x18_lanes: assert property (
      width_mode_a == WM_X18 |-> be[0][DATA_W-1:2*LANE_W] == '0 &&
                                 be[0][LANE_W-1] == mask_r[0][0])
      else $error("lane map wrong at 18 bits");

   a_byte_lanes: assert property (
      width_mode_a == WM_X32 |-> be[0][8] == 1'b0 && be[0][7] == mask_r[0][0] &&
                                 be[0][34] == mask_r[0][3])
      else $error("8-bit lane map wrong");

endmodule

`default_nettype wire

/* File: user_port.sv */
// user logic model that drives one port of the embedded ram block
// assumes clk is the block system clock; one access strobe per call
`timescale 1ns/10ps
`default_nettype none

module user_port
   import emb_ram_pkg::*;
(
   // clock
   input  wire logic              clk,
   // port controls and data
   output logic                   strobe,
   output logic                   gate,
   output logic                   we,
   output logic [ADDR_W-1:0]      addr,
   output logic [LANES-1:0]       mask,
   output logic [DATA_W-1:0]      data
);

   // ==========================================
   // idle levels at time zero
   initial
   begin
      strobe = 1'b0;
      gate   = 1'b1;
      we     = 1'b0;
      addr   = ADDR_RESET;
      mask   = MASK_RESET;
      data   = Q_RESET;
   end

   // ==========================================
   // one access, held up to its capture edge
   // own strobe, select, gate
   task automatic access(input logic g, input logic w, input logic [ADDR_W-1:0] a,
                         input logic [LANES-1:0] m, input logic [DATA_W-1:0] d);
      @(posedge clk);
      strobe <= 1'b1;
      gate   <= g;
      we     <= w;
      addr   <= a;
      mask   <= m;
      data   <= d;
      @(posedge clk);
      strobe <= 1'b0;
      gate   <= 1'b1;
      we     <= 1'b0;
      // released lines show the inverse, not stale values
      addr   <= ~a;
      mask   <= ~m;
      data   <= ~d;
   endtask

endmodule

`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the embedded ram block
// assumes two user_port models drive ports a and b; fixed latencies
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   import emb_ram_pkg::*;

   // ==========================================
   // signals
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic [2:0]        mode_a = WM_X36;
   logic [2:0]        mode_b = WM_X36;
   logic              single_port = 1'b0;
   logic              split_mode = 1'b0;
   logic              bypass_a = 1'b1;
   logic              bypass_b = 1'b1;
   logic              sel_in_b = 1'b1;
   logic              clr_a = 1'b0;
   logic              clr_b = 1'b0;
   wire logic         clock_a, clocken_a, renwe_a, clock_b, clocken_b, renwe_b;
   wire logic [6:0]   addr_a, addr_b;
   wire logic [3:0]   lm_a, lm_b;
   wire logic [35:0]  wd_a, wd_b, q_a, q_b;
   int                n_errors = 0;
   int                checks = 0;

   // 4 ns clock
   always #2 clk = ~clk;

   // ==========================================
   // design and partner models
   embedded_ram_block i_embedded_ram_block (
      .clk(clk), .rst_n(rst_n), .width_mode_a(mode_a), .width_mode_b(mode_b),
      .single_port(single_port), .split_mode(split_mode), .bypass_a(bypass_a),
      .bypass_b(bypass_b), .in_clk_sel_a(1'b0), .in_clk_sel_b(sel_in_b),
      .out_clk_sel_a(1'b0), .out_clk_sel_b(1'b1), .clock_a(clock_a),
      .clocken_a(clocken_a), .renwe_a(renwe_a), .clr_a(clr_a), .addr_a(addr_a),
      .lane_mask_a(lm_a), .wdata_a(wd_a), .q_a(q_a), .clock_b(clock_b),
      .clocken_b(clocken_b), .renwe_b(renwe_b), .clr_b(clr_b), .addr_b(addr_b),
      .lane_mask_b(lm_b), .wdata_b(wd_b), .q_b(q_b));
   user_port i_user_port_a (.clk(clk), .strobe(clock_a), .gate(clocken_a),
      .we(renwe_a), .addr(addr_a), .mask(lm_a), .data(wd_a));
   user_port i_user_port_b (.clk(clk), .strobe(clock_b), .gate(clocken_b),
      .we(renwe_b), .addr(addr_b), .mask(lm_b), .data(wd_b));

   // ==========================================
   // shared helpers
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr_a(input logic [6:0] a, input logic [3:0] m, input logic [35:0] d);
      i_user_port_a.access(1'b1, 1'b1, a, m, d);
   endtask

   task automatic rd_a(input logic [6:0] a, input logic [35:0] e);
      i_user_port_a.access(1'b1, 1'b0, a, 4'h0, 36'h0);
      @(posedge clk);
      #1 chk(q_a, e);
   endtask

   task automatic rd_b(input logic [6:0] a, input logic [35:0] e);
      i_user_port_b.access(1'b1, 1'b0, a, 4'h0, 36'h0);
      @(posedge clk);
      #1 chk(q_b, e);
   endtask

   task automatic wrap_up;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ==========================================
   // scenarios
   task automatic t_lanes;
      wr_a(7'h05, 4'hf, 36'hf_ffff_ffff);
      wr_a(7'h05, 4'h5, 36'h0);
      rd_a(7'h05, 36'hf_f803_fe00);
      wr_a(7'h05, 4'h0, 36'h0);
      rd_a(7'h05, 36'hf_f803_fe00);
      $display("t_lanes done");
   endtask

   task automatic t_widths;
      // fill both words at full width first, so no bit is left unknown
      wr_a(7'h06, 4'hf, 36'hf_ffff_ffff);
      wr_a(7'h07, 4'hf, 36'hf_ffff_ffff);
      @(posedge clk) mode_a <= WM_X16;
      wr_a(7'h06, 4'hf, 36'h0);
      rd_a(7'h06, 36'hf_fffe_0100);
      @(posedge clk) mode_a <= WM_X32;
      wr_a(7'h06, 4'hf, 36'h0);
      rd_a(7'h06, 36'h8_0402_0100);
      @(posedge clk) mode_a <= WM_X18;
      wr_a(7'h07, 4'hc, 36'h0);
      rd_a(7'h07, 36'hf_ffff_ffff);
      @(posedge clk) mode_a <= WM_NARROW;
      wr_a(7'h08, 4'h0, 36'h1_2345_6789);
      rd_a(7'h08, 36'h1_2345_6789);
      @(posedge clk) mode_a <= WM_X36;
      $display("t_widths done");
   endtask

   task automatic t_ports;
      i_user_port_b.access(1'b1, 1'b1, 7'h7f, 4'hf, 36'h9_abcd_ef01);
      rd_a(7'h7f, 36'h9_abcd_ef01);
      wr_a(7'h00, 4'hf, 36'h5_a5a5_a5a5);
      rd_b(7'h00, 36'h5_a5a5_a5a5);
      // port b inputs moved onto the idle port a clock
      @(posedge clk) sel_in_b <= 1'b0;
      i_user_port_b.access(1'b1, 1'b1, 7'h7f, 4'hf, 36'h0);
      @(posedge clk) sel_in_b <= 1'b1;
      rd_b(7'h7f, 36'h9_abcd_ef01);
      $display("t_ports done");
   endtask

   task automatic t_outreg;
      wr_a(7'h0a, 4'hf, 36'h3_c3c3_c3c3);
      @(posedge clk);
      clr_a <= 1'b1;
      clr_b <= 1'b1;
      @(posedge clk);
      clr_a <= 1'b0;
      clr_b <= 1'b0;
      #1 chk(q_a, 36'h0);
      chk(q_b, 36'h0);
      @(posedge clk) bypass_a <= 1'b0;
      // registered: the strobe moves the previous read data up first
      i_user_port_a.access(1'b1, 1'b0, 7'h0a, 4'h0, 36'h0);
      @(posedge clk);
      #1 chk(q_a, 36'h9_abcd_ef01);
      i_user_port_a.access(1'b1, 1'b0, 7'h0a, 4'h0, 36'h0);
      #1 chk(q_a, 36'h3_c3c3_c3c3);
      @(posedge clk) bypass_a <= 1'b1;
      i_user_port_a.access(1'b0, 1'b1, 7'h0a, 4'hf, 36'h0);
      rd_a(7'h0a, 36'h3_c3c3_c3c3);
      $display("t_outreg done");
   endtask

   task automatic t_split;
      @(posedge clk);
      mode_a <= WM_NARROW;
      mode_b <= WM_NARROW;
      split_mode <= 1'b1;
      wr_a(7'h03, 4'h0, 36'h0_1111_1111);
      i_user_port_b.access(1'b1, 1'b1, 7'h03, 4'h0, 36'h0_2222_2222);
      rd_a(7'h43, 36'h0_1111_1111);
      rd_b(7'h03, 36'h0_2222_2222);
      @(posedge clk);
      split_mode <= 1'b0;
      single_port <= 1'b1;
      wr_a(7'h14, 4'h0, 36'h0_7777_7777);
      i_user_port_b.access(1'b1, 1'b1, 7'h14, 4'h0, 36'h0);
      rd_a(7'h14, 36'h0_7777_7777);
      $display("t_split done");
   endtask

   // ==========================================
   // main sequence: reset for 6 cycles, then scenarios
   initial
   begin
      repeat (5) @(posedge clk);
      #1 chk(q_a, Q_RESET);
      @(posedge clk) rst_n <= 1'b1;
      t_lanes();
      t_widths();
      t_ports();
      t_outreg();
      t_split();
      wrap_up();
   end

   // hang guard
   initial
   begin
      #200000;
      n_errors++;
      wrap_up();
   end

endmodule

`default_nettype wire
